/* design/adc_ctrl_pkg.sv */
// Shared constants for the converter result and mode control block
`default_nettype none
package adc_ctrl_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_CH = 16;
   localparam int RES_W = 10;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int CSR_W = 8;
   // ----------------------------------------
   // Register indices on the link
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] RESULT_BASE_IDX = 5'h00;
   localparam logic [ADDR_W-1:0] CSR_IDX = 5'h10;
   localparam logic [ADDR_W-1:0] START_IDX = 5'h11;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
   localparam logic [CSR_W-1:0] CSR_RESET = 8'h00;
   // ----------------------------------------
   // Control/status field positions
   // ----------------------------------------
   localparam int FLAG_BIT = 7;
   localparam int IE_BIT = 6;
   localparam int MODE_HI_BIT = 5;
   localparam int MODE_LO_BIT = 4;
   localparam int CH3_BIT = 3;
   localparam int CH2_BIT = 2;
   localparam int RES_LOW_SHIFT = 6;
   // ----------------------------------------
   // Mode codes
   // ----------------------------------------
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_SCAN4 = 2'h1;
   localparam logic [1:0] MODE_SCAN8 = 2'h2;
   localparam logic [1:0] MODE_SCAN12 = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} conv_state_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

/* design/adc_link_if.sv */
// Link between the converter control block and its bus-side controller
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
   import adc_ctrl_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic wr;
   logic rd;
   logic [CSR_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic end_irq;
   logic dma_ack;
   logic start_bit;
   logic start_clear;
   modport dev (
      input addr, wr, rd, wdata, dma_ack, start_bit,
      output rdata, end_irq, start_clear
   );
   modport host (
      output addr, wr, rd, wdata, dma_ack, start_bit,
      input rdata, end_irq, start_clear
   );
endinterface : adc_link_if
`default_nettype wire

/* design/adc_result_and_mode_control.sv */
// Converter result registers, control/status register and channel sequencer
//
// Behaviour
// - Result bits 9:2 high byte, 1:0 at 7:6.
// - Sixteen read-only results, channel n into register n.
// - Results zero on reset and standby.
// - Control/status eight bits, zero on reset, standby.
// - End flag set once result stored.
// - Flag cleared by read-as-one then write zero.
// - DMA activation by end request clears flag.
// - Single mode converts once then idles.
// - Scan sets flag per group, keeps converting.
// - End request is flag AND enable.
// - Mode field 5:4 selects single or scan.
// - Single mode group from 3:2, channel 1:0.
// - Four-channel scan: group 3:2, channels 0..k.
// - Eight-channel scan: groups 0,1, channels 0..k.
// - Twelve-channel scan: groups 0..2, channels 0..k.
// - Software keeps select bit 2 zero with bit 3 in eight- and twelve-channel scans.
// - Software never uses eight-channel scan with bit 3.
// - Software stops conversion before changing selection.
// - Start bit self-clears at single-mode end only.
// - End request doubles as DMA activation request.
`timescale 1ns/10ps
`default_nettype none
module adc_result_and_mode_control (
   input wire logic clk,
   input wire logic rst,
   adc_link_if.dev link,
   input wire logic standby,
   output logic conv_req,
   output logic [3:0] conv_channel,
   input wire logic conv_done,
   input wire logic [adc_ctrl_pkg::RES_W-1:0] conv_result
);
   import adc_ctrl_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [RES_W-1:0] result_r [NUM_CH];
   logic flag_r;
   logic flag_seen_r;
   logic ie_r;
   logic [1:0] mode_r;
   logic [3:0] chsel_r;
   conv_state_t state_r;
   logic [1:0] grp_r;
   logic [1:0] idx_r;
   logic [DATA_W-1:0] rdata_r;

   logic clr_all;
   logic csr_wr;
   logic csr_rd;
   logic [1:0] sel_grp;
   logic [1:0] first_grp;
   logic [1:0] last_grp;
   logic [1:0] span_k;
   logic single;
   logic done_ok;
   logic group_end;
   logic flag_set;
   logic flag_clr;

   // Standby wipes the same state as a power-on reset
   assign clr_all = rst | standby;
   assign csr_wr = link.wr && (link.addr == CSR_IDX);
   assign csr_rd = link.rd && (link.addr == CSR_IDX);

   // ----------------------------------------
   // Channel decoding
   // ----------------------------------------
   always_comb begin
      // Select 01 has no group of its own; it falls back to group 0
      if (chsel_r[3:2] == 2'h3) begin
         sel_grp = 2'h1;
      end else if (chsel_r[3:2] == 2'h2) begin
         sel_grp = 2'h2;
      end else begin
         sel_grp = 2'h0;
      end
   end

   assign single = (mode_r == MODE_SINGLE);
   assign span_k = chsel_r[1:0];

   always_comb begin
      case (mode_r)
         MODE_SCAN8: begin
            first_grp = 2'h0;
            last_grp = 2'h1;
         end
         MODE_SCAN12: begin
            first_grp = 2'h0;
            last_grp = 2'h2;
         end
         default: begin
            first_grp = sel_grp;
            last_grp = sel_grp;
         end
      endcase
   end

   assign done_ok = (state_r == ST_WAIT) && conv_done && link.start_bit;
   assign group_end = single || (idx_r == span_k);
   assign flag_set = done_ok && group_end;
   assign flag_clr = link.dma_ack || (csr_wr && !link.wdata[FLAG_BIT] && flag_seen_r);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (clr_all) begin
         state_r <= ST_IDLE;
         grp_r <= 2'h0;
         idx_r <= 2'h0;
         conv_req <= 1'b0;
         conv_channel <= 4'h0;
      end else begin
         conv_req <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (link.start_bit) begin
                  grp_r <= first_grp;
                  idx_r <= single ? span_k : 2'h0;
                  state_r <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (!link.start_bit) begin
                  state_r <= ST_IDLE;
               end else begin
                  conv_req <= 1'b1;
                  conv_channel <= {grp_r, idx_r};
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // Stopping mid-conversion discards the pending result
               if (!link.start_bit) begin
                  state_r <= ST_IDLE;
               end else if (conv_done) begin
                  if (single) begin
                     state_r <= ST_IDLE;
                  end else begin
                     state_r <= ST_REQ;
                     if (idx_r == span_k) begin
                        idx_r <= 2'h0;
                        grp_r <= (grp_r == last_grp) ? first_grp : grp_r + 2'h1;
                     end else begin
                        idx_r <= idx_r + 2'h1;
                     end
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Pulse that tells the start-bit owner to drop it
   assign link.start_clear = done_ok && single;

   // ----------------------------------------
   // Result store
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_res
         always_ff @(posedge clk) begin
            if (clr_all) begin
               result_r[gi] <= RESULT_RESET;
            end else if (done_ok && (conv_channel == 4'(gi))) begin
               result_r[gi] <= conv_result;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Control/status register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (clr_all) begin
         ie_r <= CSR_RESET[IE_BIT];
         mode_r <= CSR_RESET[MODE_HI_BIT:MODE_LO_BIT];
         chsel_r <= CSR_RESET[CH3_BIT:0];
      end else if (csr_wr) begin
         ie_r <= link.wdata[IE_BIT];
         mode_r <= link.wdata[MODE_HI_BIT:MODE_LO_BIT];
         chsel_r <= link.wdata[CH3_BIT:0];
      end
   end

   // Setting wins over a clear in the same cycle so no end is lost
   always_ff @(posedge clk) begin
      if (clr_all) begin
         flag_r <= CSR_RESET[FLAG_BIT];
      end else if (flag_set) begin
         flag_r <= 1'b1;
      end else if (flag_clr) begin
         flag_r <= 1'b0;
      end
   end

   // A write of one to the flag never sets it; a zero needs a prior read of one
   always_ff @(posedge clk) begin
      if (clr_all) begin
         flag_seen_r <= 1'b0;
      end else if (csr_rd && flag_r) begin
         flag_seen_r <= 1'b1;
      end else if (csr_wr || !flag_r) begin
         flag_seen_r <= 1'b0;
      end
   end

   assign link.end_irq = flag_r && ie_r;

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (clr_all || !link.rd) begin
         rdata_r <= 16'h0000;
      end else if (link.addr < (RESULT_BASE_IDX + 5'(NUM_CH))) begin
         rdata_r <= {result_r[link.addr[3:0]], {RES_LOW_SHIFT{1'b0}}};
      end else if (link.addr == CSR_IDX) begin
         rdata_r <= {8'h00, flag_r, ie_r, mode_r, chsel_r};
      end else begin
         rdata_r <= 16'h0000;
      end
   end

   assign link.rdata = rdata_r;
endmodule : adc_result_and_mode_control
`default_nettype wire

/* design/adc_bus_controller.sv */
// Bus-side party: software port, start bit, flag clearing and DMA activation
`timescale 1ns/10ps
`default_nettype none
module adc_bus_controller (
   input wire logic clk,
   input wire logic rst,
   adc_link_if.host link,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] sw_addr,
   input wire logic [adc_ctrl_pkg::CSR_W-1:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [adc_ctrl_pkg::DATA_W-1:0] sw_rdata,
   input wire logic dma_enable,
   output logic cpu_irq,
   output logic dma_start
);
   import adc_ctrl_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic start_r;
   logic seen_r;
   logic rd_csr_r;
   logic rd_start_r;
   logic [6:0] shadow_r;
   logic dma_ack_r;
   logic csr_wr;
   logic refuse;
   logic [CSR_W-1:0] wr_val;
   logic seen_now;

   assign csr_wr = sw_wr && (sw_addr == CSR_IDX);
   // Reserved combination is dropped outright
   assign refuse = (sw_wdata[MODE_HI_BIT:MODE_LO_BIT] == MODE_SCAN8)
      && sw_wdata[CH3_BIT];
   // A read of one returning this cycle already allows a back-to-back clear
   assign seen_now = seen_r || (rd_csr_r && link.rdata[FLAG_BIT]);

   always_comb begin
      wr_val = sw_wdata;
      // In the wide scans a set bit 3 means group 2; single and four-channel need 11 for group 1
      wr_val[CH2_BIT] = sw_wdata[CH2_BIT]
         && !(sw_wdata[CH3_BIT] && sw_wdata[MODE_HI_BIT]);
      // While running only the flag clear passes; the rest keeps its value
      if (start_r) begin
         wr_val[6:0] = shadow_r;
      end
      // A one leaves the flag alone, so send one unless a clear is allowed
      wr_val[FLAG_BIT] = !(seen_now && !sw_wdata[FLAG_BIT]);
   end

   // ----------------------------------------
   // Link drive
   // ----------------------------------------
   assign link.addr = sw_addr;
   assign link.wdata = wr_val;
   assign link.wr = csr_wr ? !refuse : (sw_wr && (sw_addr != START_IDX));
   assign link.rd = sw_rd && (sw_addr != START_IDX);
   assign link.start_bit = start_r;
   assign link.dma_ack = dma_ack_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         shadow_r <= CSR_RESET[6:0];
      end else if (csr_wr && !refuse) begin
         shadow_r <= wr_val[6:0];
      end
   end

   // A software write wins over the device's clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         start_r <= 1'b0;
      end else if (sw_wr && (sw_addr == START_IDX)) begin
         start_r <= sw_wdata[0];
      end else if (link.start_clear) begin
         start_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read return and flag tracking
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_csr_r <= 1'b0;
         rd_start_r <= 1'b0;
      end else begin
         rd_csr_r <= sw_rd && (sw_addr == CSR_IDX);
         rd_start_r <= sw_rd && (sw_addr == START_IDX);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         seen_r <= 1'b0;
      end else if (csr_wr || link.dma_ack) begin
         seen_r <= 1'b0;
      end else if (rd_csr_r && link.rdata[FLAG_BIT]) begin
         seen_r <= 1'b1;
      end
   end

   assign sw_rdata = rd_start_r ? {15'h0000, start_r} : link.rdata;

   // ----------------------------------------
   // Interrupt routing and DMA activation
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         dma_ack_r <= 1'b0;
      end else begin
         dma_ack_r <= link.end_irq && dma_enable && !dma_ack_r;
      end
   end

   assign dma_start = dma_ack_r;
   assign cpu_irq = link.end_irq && !dma_enable;
endmodule : adc_bus_controller
`default_nettype wire

/* bench/adc_link_assertions.sv */
// Link checker for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_link_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [adc_ctrl_pkg::CSR_W-1:0] wdata,
   input wire logic [adc_ctrl_pkg::DATA_W-1:0] rdata,
   input wire logic end_irq,
   input wire logic dma_ack,
   input wire logic start_bit,
   input wire logic start_clear
);
   import adc_ctrl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Link properties
   // ----------------------------------------
   a_quiet_rdata: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside a read");
   a_result_low_zero: assert property ($past(rd) && $past(addr) < CSR_IDX |->
      rdata[5:0] == 6'h00)
      else $error("result low bits not zero");
   a_csr_upper_zero: assert property ($past(rd) && $past(addr) == CSR_IDX |->
      rdata[15:8] == 8'h00)
      else $error("status read wider than eight bits");
   // Flag and enable seen in the read must match the request line of that cycle
   a_irq_matches_csr: assert property ($past(rd) && $past(addr) == CSR_IDX |->
      (rdata[7] & rdata[6]) == $past(end_irq))
      else $error("end request not flag and enable");
   a_dma_clears_flag: assert property (dma_ack && !start_bit |=> !end_irq)
      else $error("flag kept after DMA activation");
   a_dma_needs_irq: assert property (dma_ack |-> $past(end_irq))
      else $error("DMA activation without end request");
   a_single_stops: assert property (start_clear |=> !start_bit)
      else $error("start bit kept after single conversion");
   a_no_reserved_mode: assert property (wr && addr == CSR_IDX |->
      !(wdata[5:4] == 2'h2 && wdata[3]))
      else $error("reserved scan setting reached the device");
endmodule : adc_link_assertions
`default_nettype wire

/* bench/tb.sv */
// Testbench for the converter control block and its bus-side controller
`timescale 1ns/10ps
`default_nettype none
module tb;
   import adc_ctrl_pkg::*;
   logic clk, rst, standby, conv_done, conv_req, sw_wr, sw_rd, dma_enable, cpu_irq, dma_start;
   logic [3:0] conv_channel;
   logic [RES_W-1:0] conv_result;
   logic [ADDR_W-1:0] sw_addr;
   logic [CSR_W-1:0] sw_wdata;
   logic [DATA_W-1:0] sw_rdata;
   int num_errors = 0;
   int checks_done = 0;
   adc_link_if adc_link_if_i ();
   adc_result_and_mode_control adc_result_and_mode_control_i (.clk(clk), .rst(rst),
      .link(adc_link_if_i), .standby(standby), .conv_req(conv_req),
      .conv_channel(conv_channel), .conv_done(conv_done), .conv_result(conv_result));
   adc_bus_controller adc_bus_controller_i (.clk(clk), .rst(rst), .link(adc_link_if_i),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .dma_enable(dma_enable), .cpu_irq(cpu_irq), .dma_start(dma_start));
   adc_link_assertions adc_link_assertions_i (.clk(clk), .rst(rst), .addr(adc_link_if_i.addr),
      .wr(adc_link_if_i.wr), .rd(adc_link_if_i.rd), .wdata(adc_link_if_i.wdata),
      .rdata(adc_link_if_i.rdata), .end_irq(adc_link_if_i.end_irq),
      .dma_ack(adc_link_if_i.dma_ack), .start_bit(adc_link_if_i.start_bit),
      .start_clear(adc_link_if_i.start_clear));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // A missed handshake would hang the run, so it ends it instead
   task automatic expire(input logic seen);
      if (seen !== 1'b1) begin
         chk(16'h0000, 16'h0001);
         report_and_stop();
      end
   endtask : expire
   task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      @(negedge clk);
      chk(sw_rdata, exp);
   endtask : bus_rd
   // Plays the converter: answers one request with a result
   task automatic conv(input logic [3:0] ch, input logic [9:0] v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (conv_req !== 1'b1 && n < 40);
      expire(conv_req);
      chk({12'h000, conv_channel}, {12'h000, ch});
      @(posedge clk);
      conv_done <= 1'b1;
      conv_result <= v;
      @(posedge clk);
      conv_done <= 1'b0;
   endtask : conv
   task automatic irq_is(input logic e);
      @(negedge clk);
      chk({15'h0000, cpu_irq}, {15'h0000, e});
   endtask : irq_is
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_single;
      logic [3:0] sel [3] = '{4'h1, 4'hE, 4'hB};
      logic [3:0] ch [3] = '{4'h1, 4'h6, 4'hB};
      logic [9:0] v [3] = '{10'h3FF, 10'h2C5, 10'h001};
      for (int i = 0; i < 3; i++) begin
         bus_wr(CSR_IDX, {4'h4, sel[i]});
         bus_wr(START_IDX, 8'h01);
         conv(ch[i], v[i]);
         irq_is(1'b1);
         bus_rd(START_IDX, 16'h0000);
         bus_rd({1'b0, ch[i]}, {v[i], 6'h00});
         bus_wr(CSR_IDX, {4'h4, sel[i]});
         bus_rd(CSR_IDX, {8'h00, 4'hC, sel[i]});
         bus_wr(CSR_IDX, {4'h4, sel[i]});
         irq_is(1'b0);
      end
      $display("single mode test done");
   endtask : t_single
   task automatic t_scan4;
      bus_wr(CSR_IDX, 8'h5D);
      bus_wr(START_IDX, 8'h01);
      conv(4'h4, 10'h111);
      irq_is(1'b0);
      conv(4'h5, 10'h222);
      irq_is(1'b1);
      conv(4'h4, 10'h333);
      bus_rd(START_IDX, 16'h0001);
      bus_wr(START_IDX, 8'h00);
      bus_rd(5'h05, {10'h222, 6'h00});
      bus_rd(CSR_IDX, 16'h00DD);
      bus_wr(CSR_IDX, 8'h5D);
      $display("four-channel scan test done");
   endtask : t_scan4
   task automatic t_scan8;
      bus_wr(CSR_IDX, 8'h61);
      bus_wr(START_IDX, 8'h01);
      conv(4'h0, 10'h0AA);
      irq_is(1'b0);
      conv(4'h1, 10'h155);
      irq_is(1'b1);
      conv(4'h4, 10'h0F0);
      conv(4'h5, 10'h30F);
      conv(4'h0, 10'h0AA);
      bus_wr(START_IDX, 8'h00);
      bus_rd(CSR_IDX, 16'h00E1);
      bus_wr(CSR_IDX, 8'h61);
      $display("eight-channel scan test done");
   endtask : t_scan8
   task automatic t_scan12;
      bus_wr(CSR_IDX, 8'h78);
      bus_wr(START_IDX, 8'h01);
      conv(4'h0, 10'h200);
      irq_is(1'b1);
      conv(4'h4, 10'h201);
      conv(4'h8, 10'h202);
      conv(4'h0, 10'h203);
      bus_wr(START_IDX, 8'h00);
      bus_rd(CSR_IDX, 16'h00F8);
      bus_wr(CSR_IDX, 8'h78);
      bus_wr(CSR_IDX, 8'h2C);
      bus_rd(CSR_IDX, 16'h0078);
      bus_wr(CSR_IDX, 8'h7C);
      bus_rd(CSR_IDX, 16'h0078);
      bus_wr(CSR_IDX, 8'h80);
      bus_rd(CSR_IDX, 16'h0000);
      $display("twelve-channel scan test done");
   endtask : t_scan12
   task automatic t_dma;
      int n;
      @(posedge clk);
      dma_enable <= 1'b1;
      bus_wr(CSR_IDX, 8'h42);
      bus_wr(START_IDX, 8'h01);
      conv(4'h2, 10'h155);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (dma_start !== 1'b1 && n < 5);
      expire(dma_start);
      bus_rd(CSR_IDX, 16'h0042);
      @(posedge clk);
      dma_enable <= 1'b0;
      standby <= 1'b1;
      @(posedge clk);
      standby <= 1'b0;
      bus_rd(5'h02, 16'h0000);
      bus_rd(CSR_IDX, 16'h0000);
      $display("DMA and standby test done");
   endtask : t_dma
   initial begin
      rst = 1'b1;
      standby = 1'b0;
      conv_done = 1'b0;
      conv_result = 10'h000;
      sw_addr = 5'h00;
      sw_wdata = 8'h00;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      dma_enable = 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 17; i++) bus_rd(i[4:0], 16'h0000);
      $display("reset value test done");
      t_single();
      t_scan4();
      t_scan8();
      t_scan12();
      t_dma();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
